/* common/hti_pkg.sv */
// Purpose: shared constants, types and checksum for the sensor command port
// Assumes: system clock of CLK_MHZ; all times in microseconds
// Notes: used by the sensor end and the controller end
package hti_pkg;
  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_MEAS_L_US = 1600;
  localparam int unsigned T_MEAS_M_US = 4500;
  localparam int unsigned T_MEAS_H_US = 8300;
  localparam int unsigned T_HEAT_LONG_US = 1000000;
  localparam int unsigned T_HEAT_SHORT_US = 100000;
  localparam int unsigned T_SRST_US = 1000;
  // ==========================================================================
  // addresses and commands
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] CMD_MEAS_H = 8'hfd;
  localparam logic [7:0] CMD_MEAS_M = 8'hf6;
  localparam logic [7:0] CMD_MEAS_L = 8'he0;
  localparam logic [7:0] CMD_SERIAL = 8'h89;
  localparam logic [7:0] CMD_SRESET = 8'h94;
  localparam logic [7:0] CMD_H200_L = 8'h39;
  localparam logic [7:0] CMD_H200_S = 8'h32;
  localparam logic [7:0] CMD_H110_L = 8'h2f;
  localparam logic [7:0] CMD_H110_S = 8'h24;
  localparam logic [7:0] CMD_H20_L = 8'h1e;
  localparam logic [7:0] CMD_H20_S = 8'h15;
  // ==========================================================================
  // framing and checksum
  localparam logic [2:0] RESP_LAST = 3'h5;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_XOR = 8'h00;

  typedef enum logic [1:0] {HTR_OFF, HTR_20, HTR_110, HTR_200} hti_htr_t;

  function automatic logic [7:0] hti_crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ CRC_XOR;
  endfunction
endpackage

/* common/hti_if.sv */
// Purpose: two-wire link between sensor end and controller end
// Assumes: open-drain lines with pull-ups; a driver only ever pulls low
// Notes: line levels are resolved here from the output enables
`timescale 1ns/10ps
interface hti_if;
  logic scl_o;
  logic scl_oe;
  logic hsda_o;
  logic hsda_oe;
  logic dsda_o;
  logic dsda_oe;
  logic scl;
  logic sda;

  assign scl = !(scl_oe && !scl_o);
  assign sda = !((hsda_oe && !hsda_o) || (dsda_oe && !dsda_o));

  modport dev(input scl, input sda, output dsda_o, output dsda_oe);
  modport host(input scl, input sda, output scl_o, output scl_oe, output hsda_o, output hsda_oe);
endinterface

/* rtl/hti_dev.sv */
// Purpose: sensor end: two-wire target, command decode, timed actions
// Assumes: SCL and SDA are asynchronous pins sampled by CLK
// Notes: measured values and serial number come in on user ports
// Contract
// - target at standard, fast, fast-plus speeds
// - payload as 16-bit words of two bytes
// - controller frames transfers with START and STOP
// - controller ends read with NACK, STOP
// - header: 7-bit address plus direction bit
// - sensor never stretches the clock
// - read header while busy gets NACK
// - result dropped after first acked read
// - checksum byte after every data pair
// - temperature word first, then humidity
// - CRC-8, poly 0x31, init 0xFF
// - read may stop before checksum byte
// - 0xFD/0xF6/0xE0 measure high/med/low
// - 0x39/0x32 heater 200 mW long/short
// - 0x2F/0x24 heater 110 mW long/short
// - 0x1E/0x15 heater 20 mW long/short
// - heater ends with high-repeatability measurement
// - heat, measure heated, heater off, readable
// - 0x89 returns two serial words with CRC
// - soft reset back idle within 1 ms
// - general call 0x06 resets like soft reset
`timescale 1ns/10ps
module hti_dev
  import hti_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int unsigned MEAS_L_CYC = T_MEAS_L_US * CLK_MHZ,
  parameter int unsigned MEAS_M_CYC = T_MEAS_M_US * CLK_MHZ,
  parameter int unsigned MEAS_H_CYC = T_MEAS_H_US * CLK_MHZ,
  parameter int unsigned HEAT_L_CYC = T_HEAT_LONG_US * CLK_MHZ,
  parameter int unsigned HEAT_S_CYC = T_HEAT_SHORT_US * CLK_MHZ,
  parameter int unsigned SRST_CYC = T_SRST_US * CLK_MHZ
) (
  input wire logic CLK,
  input wire logic ARST_N,
  hti_if.dev BUS,
  input wire logic [15:0] MEAS_T,
  input wire logic [15:0] MEAS_RH,
  input wire logic [31:0] SERIAL_NUM,
  output logic HEATER_EN,
  output hti_htr_t HEATER_LVL,
  output logic RESULT_READY
);
  if (MEAS_L_CYC < 1 || MEAS_M_CYC < 1 || MEAS_H_CYC < 1 || HEAT_L_CYC < 1 || HEAT_S_CYC < 1 ||
      SRST_CYC < 1) begin : g_chk
    $error("hti_dev: every duration needs at least one cycle");
  end

  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_AACK, B_CMD, B_CACK, B_TX, B_TACK, B_WAIT} hti_bus_t;
  typedef enum logic [2:0] {A_IDLE, A_MEAS, A_HEAT, A_HMEAS, A_RST} hti_act_t;

  function automatic logic cmd_known(input logic [7:0] c);
    return c inside {CMD_MEAS_H, CMD_MEAS_M, CMD_MEAS_L, CMD_SERIAL, CMD_SRESET,
                     CMD_H200_L, CMD_H200_S, CMD_H110_L, CMD_H110_S, CMD_H20_L, CMD_H20_S};
  endfunction

  function automatic logic [7:0] resp_byte(input logic [31:0] w, input logic [2:0] idx);
    unique case (idx)
      3'h0: return w[31:24];
      3'h1: return w[23:16];
      3'h2: return hti_crc8(w[31:16]);
      3'h3: return w[15:8];
      3'h4: return w[7:0];
      default: return hti_crc8(w[15:0]);
    endcase
  endfunction

  // ==========================================================================
  // pin synchronisers and bus events
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], BUS.scl};
      sda_s <= {sda_s[0], BUS.sda};
      scl_d_r <= scl_s[1];
      sda_d_r <= sda_s[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s[1] && !scl_d_r;
  assign scl_fall = !scl_s[1] && scl_d_r;
  assign bus_start = scl_s[1] && scl_d_r && sda_d_r && !sda_s[1];
  assign bus_stop = scl_s[1] && scl_d_r && !sda_d_r && sda_s[1];

  // ==========================================================================
  // bus state machine
  hti_bus_t st_r;
  hti_act_t act_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic oe_r;
  logic gc_r;
  logic rd_r;
  logic mack_r;
  logic res_valid_r;
  logic q_valid;
  logic [7:0] q_data;

  logic busy;
  logic hdr_ack;
  logic cmd_ok;
  logic hdr_done;
  logic cmd_go;
  logic rd_go;
  logic pop;
  assign busy = act_r != A_IDLE;
  assign hdr_done = st_r == B_ADDR && scl_fall && cnt_r == BIT_ACK;
  assign hdr_ack = (sh_r[7:1] == DEV_ADDR && (!sh_r[0] || (res_valid_r && !busy))) ||
                   (sh_r[7:1] == GC_ADDR && !sh_r[0]);
  assign cmd_ok = gc_r ? sh_r == GC_RESET : cmd_known(sh_r) && (!busy || sh_r == CMD_SRESET);
  assign cmd_go = st_r == B_CMD && scl_fall && cnt_r == BIT_ACK && cmd_ok;
  assign rd_go = hdr_done && hdr_ack && sh_r[0];
  assign pop = scl_fall && ((st_r == B_AACK && rd_r) || (st_r == B_TACK && mack_r && q_valid));

  // sda only changes after a falling scl; scl is never driven
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= B_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      oe_r <= 1'b0;
      gc_r <= 1'b0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (bus_start) begin
      st_r <= B_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end else if (bus_stop) begin
      st_r <= B_IDLE;
      oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        B_IDLE, B_WAIT: begin
        end
        B_ADDR, B_CMD: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (hdr_done) begin
            gc_r <= sh_r[7:1] == GC_ADDR;
            rd_r <= sh_r[0];
            oe_r <= hdr_ack;
            st_r <= hdr_ack ? B_AACK : B_WAIT;
          end else if (scl_fall && cnt_r == BIT_ACK) begin
            oe_r <= cmd_ok;
            st_r <= cmd_ok ? B_CACK : B_WAIT;
          end
        end
        B_AACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (rd_r) begin
              tx_r <= q_data;
              oe_r <= !q_data[7];
              st_r <= B_TX;
            end else begin
              oe_r <= 1'b0;
              st_r <= B_CMD;
            end
          end
        end
        B_CACK: begin
          if (scl_fall) begin
            oe_r <= 1'b0;
            st_r <= B_WAIT;
          end
        end
        B_TX: begin
          if (scl_fall) begin
            if (cnt_r[2:0] == BIT_LAST) begin
              oe_r <= 1'b0;
              st_r <= B_TACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              oe_r <= !tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        B_TACK: begin
          if (scl_rise) begin
            mack_r <= !sda_s[1];
          end else if (scl_fall) begin
            // a NACK from the controller ends sending at any byte
            if (mack_r && q_valid) begin
              tx_r <= q_data;
              oe_r <= !q_data[7];
              cnt_r <= 4'h0;
              st_r <= B_TX;
            end else begin
              st_r <= B_WAIT;
            end
          end
        end
      endcase
    end
  end

  assign BUS.dsda_o = 1'b0;
  assign BUS.dsda_oe = oe_r;

  // ==========================================================================
  // response generator and two-entry buffer
  logic gen_on_r;
  logic [2:0] gen_idx_r;
  logic [31:0] gen_w_r;
  logic [31:0] res_r;
  logic [7:0] d0_r;
  logic [7:0] d1_r;
  logic v0_r;
  logic v1_r;
  logic push;
  logic flush;
  assign flush = bus_start || bus_stop;
  assign push = gen_on_r && !v1_r;
  assign q_valid = v0_r;
  assign q_data = d0_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gen_on_r <= 1'b0;
      gen_idx_r <= 3'h0;
      gen_w_r <= 32'h0000_0000;
    end else if (rd_go) begin
      gen_on_r <= 1'b1;
      gen_idx_r <= 3'h0;
      gen_w_r <= res_r;
    end else if (flush) begin
      gen_on_r <= 1'b0;
    end else if (push) begin
      gen_idx_r <= gen_idx_r + 3'h1;
      gen_on_r <= gen_idx_r != RESP_LAST;
    end
  end

  // word hi, word lo, checksum, twice
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      d0_r <= 8'h00;
      d1_r <= 8'h00;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else if (flush) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else if (pop && push) begin
      d0_r <= resp_byte(gen_w_r, gen_idx_r);
      v0_r <= 1'b1;
    end else if (pop) begin
      d0_r <= d1_r;
      v0_r <= v1_r;
      v1_r <= 1'b0;
    end else if (push && v0_r) begin
      d1_r <= resp_byte(gen_w_r, gen_idx_r);
      v1_r <= 1'b1;
    end else if (push) begin
      d0_r <= resp_byte(gen_w_r, gen_idx_r);
      v0_r <= 1'b1;
    end
  end

  // ==========================================================================
  // timed actions
  logic [31:0] tmr_r;
  logic tmr_end;
  assign tmr_end = tmr_r == 32'h0000_0001;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_r <= A_IDLE;
      tmr_r <= 32'h0000_0000;
      HEATER_EN <= 1'b0;
      HEATER_LVL <= HTR_OFF;
      res_r <= 32'h0000_0000;
      res_valid_r <= 1'b0;
    end else if (cmd_go && (gc_r || sh_r == CMD_SRESET)) begin
      act_r <= A_RST;
      tmr_r <= SRST_CYC;
      HEATER_EN <= 1'b0;
      HEATER_LVL <= HTR_OFF;
      res_valid_r <= 1'b0;
    end else begin
      if (rd_go) begin
        res_valid_r <= 1'b0;
      end
      if (act_r != A_IDLE) begin
        tmr_r <= tmr_r - 32'h0000_0001;
      end
      unique case (act_r)
        A_IDLE: begin
          if (cmd_go) begin
            unique case (sh_r)
              CMD_MEAS_H, CMD_MEAS_M, CMD_MEAS_L: begin
                act_r <= A_MEAS;
                res_valid_r <= 1'b0;
                tmr_r <= sh_r == CMD_MEAS_H ? MEAS_H_CYC : sh_r == CMD_MEAS_M ? MEAS_M_CYC : MEAS_L_CYC;
              end
              CMD_H200_L, CMD_H200_S, CMD_H110_L, CMD_H110_S, CMD_H20_L, CMD_H20_S: begin
                act_r <= A_HEAT;
                res_valid_r <= 1'b0;
                HEATER_EN <= 1'b1;
                HEATER_LVL <= sh_r inside {CMD_H200_L, CMD_H200_S} ? HTR_200 :
                              sh_r inside {CMD_H110_L, CMD_H110_S} ? HTR_110 : HTR_20;
                tmr_r <= sh_r inside {CMD_H200_L, CMD_H110_L, CMD_H20_L} ? HEAT_L_CYC : HEAT_S_CYC;
              end
              CMD_SERIAL: begin
                res_r <= SERIAL_NUM;
                res_valid_r <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        A_MEAS: begin
          if (tmr_end) begin
            res_r <= {MEAS_T, MEAS_RH};
            res_valid_r <= 1'b1;
            act_r <= A_IDLE;
          end
        end
        A_HEAT: begin
          if (tmr_end) begin
            act_r <= A_HMEAS;
            tmr_r <= MEAS_H_CYC;
          end
        end
        A_HMEAS: begin
          if (tmr_end) begin
            res_r <= {MEAS_T, MEAS_RH};
            res_valid_r <= 1'b1;
            HEATER_EN <= 1'b0;
            HEATER_LVL <= HTR_OFF;
            act_r <= A_IDLE;
          end
        end
        A_RST: begin
          if (tmr_end) begin
            act_r <= A_IDLE;
          end
        end
      endcase
    end
  end

  assign RESULT_READY = res_valid_r;
endmodule

/* rtl/hti_host.sv */
// Purpose: controller end: generates SCL, sends headers and commands, reads bytes
// Assumes: SDA returns from outside the clock domain
// Notes: read bytes leave through a two-entry buffer; a full buffer holds the clock
`timescale 1ns/10ps
module hti_host
  import hti_pkg::*;
#(
  parameter int unsigned QTR_CYC = 63
) (
  input wire logic CLK,
  input wire logic ARST_N,
  hti_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [6:0] CMD_ADDR,
  input wire logic CMD_RW,
  input wire logic [7:0] CMD_BYTE,
  input wire logic [2:0] CMD_NRD,
  output logic RD_VALID,
  input wire logic RD_READY,
  output logic [7:0] RD_DATA,
  output logic DONE,
  output logic NACKED
);
  if (QTR_CYC < 4 || QTR_CYC > 255) begin : g_chk
    $error("hti_host: QTR_CYC must be 4..255");
  end

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hti_hst_t;

  // ==========================================================================
  // quarter-bit divider and sda synchroniser
  logic [7:0] div_r;
  logic tick_r;
  logic [1:0] sda_s;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == 8'(QTR_CYC - 1);
      div_r <= div_r == 8'(QTR_CYC - 1) ? 8'h00 : div_r + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], BUS.sda};
    end
  end

  // ==========================================================================
  // transfer sequencer
  hti_hst_t st_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [2:0] nb_r;
  logic [2:0] nrd_r;
  logic [7:0] sh_r;
  logic [7:0] cmd_r;
  logic rw_r;
  logic ack_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic v1_r;
  logic writing;
  logic last;
  logic stall;
  logic push;
  logic step;
  assign writing = nb_r == 3'h0 || !rw_r;
  assign last = rw_r ? nb_r == nrd_r : nb_r == 3'h1;
  assign stall = st_r == H_BIT && q_r == 2'h0 && bit_r == BIT_ACK && !writing && v1_r;
  assign step = tick_r && !stall;
  assign push = step && st_r == H_BIT && q_r == 2'h0 && bit_r == BIT_ACK && !writing;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= H_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      nb_r <= 3'h0;
      nrd_r <= 3'h0;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      CMD_READY <= 1'b1;
      DONE <= 1'b0;
      NACKED <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (st_r == H_IDLE && CMD_VALID && CMD_READY) begin
        CMD_READY <= 1'b0;
        NACKED <= 1'b0;
        sh_r <= {CMD_ADDR, CMD_RW};
        rw_r <= CMD_RW;
        cmd_r <= CMD_BYTE;
        nrd_r <= CMD_NRD;
        nb_r <= 3'h0;
        q_r <= 2'h0;
        st_r <= H_START;
      end else if (step && st_r != H_IDLE) begin
        q_r <= q_r + 2'h1;
        unique case (st_r)
          H_START: begin
            if (q_r == 2'h1) begin
              sda_oe_r <= 1'b1;
            end else if (q_r == 2'h2) begin
              scl_oe_r <= 1'b1;
            end else if (q_r == 2'h3) begin
              bit_r <= 4'h0;
              st_r <= H_BIT;
            end
          end
          H_BIT: begin
            unique case (q_r)
              2'h0: sda_oe_r <= bit_r == BIT_ACK ? (!writing && !last) : (writing && !sh_r[7]);
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bit_r == BIT_ACK) begin
                  ack_r <= !sda_s[1];
                end else begin
                  sh_r <= {sh_r[6:0], sda_s[1]};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                if (bit_r != BIT_ACK) begin
                  bit_r <= bit_r + 4'h1;
                end else if ((writing && !ack_r) || last) begin
                  NACKED <= writing && !ack_r;
                  st_r <= H_STOP;
                end else begin
                  bit_r <= 4'h0;
                  nb_r <= nb_r + 3'h1;
                  sh_r <= cmd_r;
                end
              end
            endcase
          end
          default: begin
            if (q_r == 2'h0) begin
              sda_oe_r <= 1'b1;
            end else if (q_r == 2'h1) begin
              scl_oe_r <= 1'b0;
            end else if (q_r == 2'h2) begin
              sda_oe_r <= 1'b0;
            end else begin
              st_r <= H_IDLE;
              CMD_READY <= 1'b1;
              DONE <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  assign BUS.scl_o = 1'b0;
  assign BUS.scl_oe = scl_oe_r;
  assign BUS.hsda_o = 1'b0;
  assign BUS.hsda_oe = sda_oe_r;

  // ==========================================================================
  // two-entry read buffer
  logic [7:0] d1_r;
  logic pop;
  assign pop = RD_VALID && RD_READY;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      d1_r <= 8'h00;
      v1_r <= 1'b0;
    end else if (pop && push) begin
      RD_DATA <= v1_r ? d1_r : sh_r;
      d1_r <= sh_r;
    end else if (pop) begin
      RD_DATA <= d1_r;
      RD_VALID <= v1_r;
      v1_r <= 1'b0;
    end else if (push && RD_VALID) begin
      d1_r <= sh_r;
      v1_r <= 1'b1;
    end else if (push) begin
      RD_DATA <= sh_r;
      RD_VALID <= 1'b1;
    end
  end
endmodule

/* test/hti_assertions.sv */
// Purpose: wire checks on the two-wire link
// Assumes: host QTR_CYC of 8
// Notes: sees interface signals only
`timescale 1ns/10ps
module hti_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic hsda_o,
  input wire logic hsda_oe,
  input wire logic dsda_o,
  input wire logic dsda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_no_stretch; $rose(scl) |-> scl [*8]; endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("clock low not by host");
  property p_od; dsda_oe && scl |-> !hsda_oe && !dsda_o; endproperty
  a_od: assert property (p_od) else $error("both ends drive sda in high phase");
  property p_drv_time; $rose(dsda_oe) |-> $past(scl, 5) && !$past(scl, 2); endproperty
  a_drv_time: assert property (p_drv_time) else $error("sda drive mistimed");
  property p_rel_low; $fell(dsda_oe) |-> !scl && !$past(scl, 2); endproperty
  a_rel_low: assert property (p_rel_low) else $error("sda release mistimed");
  property p_start; $fell(sda) && scl |-> scl [*4]; endproperty
  a_start: assert property (p_start) else $error("start too short");
  property p_stop; $rose(sda) && scl |=> sda [*4]; endproperty
  a_stop: assert property (p_stop) else $error("stop not idle");
  property p_bit_hold; $rose(dsda_oe) |-> dsda_oe [*8]; endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
  property p_hold_high; scl && $past(scl) |-> $stable(dsda_oe); endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda moved in high phase");
endmodule

/* test/tb_top.sv */
// Purpose: sensor end against controller end
// Assumes: short timing parameters
// Notes: read bytes gathered in a queue
`timescale 1ns/10ps
module tb_top;
  import hti_pkg::*;
  localparam logic [6:0] ADR = 7'h40;
  logic clk = 0, arst_n = 0, cv = 0, crw = 0, rdy = 1, c_rdy, rv, done, nak, htr, rres;
  logic [6:0] ca = 0;
  logic [7:0] cb = 0, rd;
  logic [2:0] cn = 0;
  logic [15:0] mt = 16'hbeef, mrh = 16'h1234;
  logic [31:0] sn = 32'h0a0b0c0d;
  hti_htr_t lvl;
  int bad_count = 0, compares = 0, cyc = 0;
  logic [7:0] q[$];
  hti_if bus();
  always #2 clk = ~clk;
  hti_dev #(.MEAS_L_CYC(200), .MEAS_M_CYC(400), .MEAS_H_CYC(600), .HEAT_L_CYC(3000), .HEAT_S_CYC(1500),
    .SRST_CYC(50)) hti_dev_i (.CLK(clk), .ARST_N(arst_n), .BUS(bus), .MEAS_T(mt), .MEAS_RH(mrh),
    .SERIAL_NUM(sn), .HEATER_EN(htr), .HEATER_LVL(lvl), .RESULT_READY(rres));
  hti_host #(.QTR_CYC(8)) hti_host_i (.CLK(clk), .ARST_N(arst_n), .BUS(bus), .CMD_VALID(cv),
    .CMD_READY(c_rdy), .CMD_ADDR(ca), .CMD_RW(crw), .CMD_BYTE(cb), .CMD_NRD(cn), .RD_VALID(rv),
    .RD_READY(rdy), .RD_DATA(rd), .DONE(done), .NACKED(nak));
  hti_chk hti_chk_i (.CLK(clk), .ARST_N(arst_n), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
    .hsda_o(bus.hsda_o), .hsda_oe(bus.hsda_oe), .dsda_o(bus.dsda_o), .dsda_oe(bus.dsda_oe),
    .scl(bus.scl), .sda(bus.sda));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv && rdy) q.push_back(rd);
  end
  always @(negedge clk) if (cyc == 90000) begin
    bad_count++;
    finish_test();
  end
  // ==========================================================================
  // helpers
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [6:0] a, input logic w, input logic [7:0] b, input logic [2:0] n);
    int k;
    k = 0;
    @(negedge clk);
    {cv, ca, crw, cb, cn} = {1'b1, a, w, b, n};
    @(negedge clk);
    cv = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(k < 20000), 16'h1);
  endtask
  task automatic rdw(input logic [2:0] n, input int ex, input logic [15:0] w0, w1, input int st);
    logic [7:0] e[6];
    e = '{w0[15:8], w0[7:0], crc(w0), w1[15:8], w1[7:0], crc(w1)};
    q = {};
    rdy = (st == 0);
    fork
      run(ADR, 1, 0, n);
      begin
        repeat (st) @(negedge clk);
        rdy = 1;
      end
    join
    repeat (2) @(negedge clk);
    chk(16'(q.size()), 16'(ex));
    foreach (q[i]) chk(16'(q[i]), 16'(e[i]));
  endtask
  task automatic wres();
    int k;
    k = 0;
    while (rres !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(rres), 16'h1);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_meas();
    logic [7:0] c[3] = '{8'hfd, 8'hf6, 8'he0};
    foreach (c[i]) begin
      run(ADR, 0, c[i], 0);
      mt = {8'hb0, c[i]};
      wres();
      rdw(6, 6, mt, mrh, 0);
      chk(16'(rres), 16'h0);
      rdw(6, 0, 0, 0, 0);
    end
  endtask
  task automatic t_heat();
    logic [7:0] c[6] = '{8'h39, 8'h32, 8'h2f, 8'h24, 8'h1e, 8'h15};
    hti_htr_t l[6] = '{HTR_200, HTR_200, HTR_110, HTR_110, HTR_20, HTR_20};
    foreach (c[i]) begin
      run(ADR, 0, c[i], 0);
      chk(16'({htr, lvl}), 16'({1'b1, l[i]}));
      rdw(6, 0, 0, 0, 0);
      mrh = {8'h4c, c[i]};
      wres();
      chk(16'({htr, lvl, rres}), 16'h1);
      rdw(6, 6, mt, mrh, 0);
    end
  endtask
  task automatic t_ser();
    run(ADR, 0, 8'h89, 0);
    rdw(6, 6, 16'h0a0b, 16'h0c0d, 1500);
    run(ADR, 0, 8'hfd, 0);
    wres();
    rdw(2, 2, mt, 0, 0);
    chk(16'(rres), 16'h0);
  endtask
  task automatic t_rst();
    run(ADR, 0, 8'h39, 0);
    run(ADR, 0, 8'h94, 0);
    repeat (50) @(negedge clk);
    chk(16'({nak, htr, rres}), 16'h0);
    rdw(6, 0, 0, 0, 0);
    run(ADR, 0, 8'h39, 0);
    chk(16'({nak, htr}), 16'h1);
    run(7'h00, 0, 8'h06, 0);
    repeat (50) @(negedge clk);
    chk(16'({nak, htr, rres}), 16'h0);
    run(ADR, 0, 8'hfd, 0);
    wres();
    run(ADR, 0, 8'h00, 0);
    chk(16'({nak, rres}), 16'h3);
    rdw(6, 6, mt, mrh, 0);
  endtask
  task automatic finish_test();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    chk(16'({bus.scl, bus.sda}), 16'h3);
    chk(16'(crc(16'hbeef)), 16'h92);
    t_meas();
    t_heat();
    t_ser();
    t_rst();
    finish_test();
  end
endmodule
